// file: core/fsp_regs.sv
// status and function registers with write latch, busy, protection and suspend
//
// Functional notes
// - busy flag is 1 while program, erase or register write runs; read-only.
// - while busy, only register reads, resets and a due suspend are accepted.
// - suspend is accepted during a running program or erase.
// - busy clears when the operation ends, then commands are accepted.
// - write-class commands are refused while the write latch is 0.
// - write-enable command sets the write latch.
// - volatile read-register settings need no write latch.
// - write-disable clears the latch; any write completion clears it too.
// - program and erase opcodes listed are latch-gated.
// - register and info-row write opcodes listed are latch-gated.
// - program or erase to a protected area is refused.
// - protect_select decodes top or bottom 64 KB block ranges, all, or none.
// - whole-array erase runs only when protect_select is zero.
// - lock bit with write-protect low freezes status bits 7..2 while quad enable is 0.
// - status write allowed when unlocked, or locked with write-protect high.
// - quad enable turns protect and pause/reset pins into data lines.
// - an info row may be programmed only while its lock bit is 0.
// - one-time-programmable function bits never return to 0 through a function write.
// - reset-off bit moves the reset function to the pause/reset pin.
// - program suspend sets program paused flag; resume clears it.
// - erase suspend sets erase paused flag; resume clears it.
// - status layout: lock 7, quad 6, protect 5..2, latch 1, busy 0.
// - write latch changes only by enable/disable commands, completion and reset, not status write data.
`timescale 1ns/10ps
module fsp_regs import fsp_pkg::*; #(
  parameter int PROG_LEN = PROG_CYCLES,
  parameter int ERASE_LEN = ERASE_CYCLES,
  parameter int REG_LEN = REG_CYCLES,
  parameter int NUM_BLOCKS = PROT_BLOCKS,
  parameter logic RST_OFF_DEFAULT = FUNC_RST_OFF_RESET
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  input wire logic i_reset_dedicated_n,
  input wire logic i_pause_reset_n,
  input wire logic i_load_nv,
  input wire logic [7:0] i_nv_status,
  input wire logic [7:0] i_nv_function,
  output logic o_so,
  output logic o_so_oe,
  output logic [7:0] o_status_word,
  output logic [7:0] o_function_word,
  output logic o_wp_func_en,
  output logic o_pause_func_en,
  output logic o_quad_io_en,
  output logic o_reset_shared_pin,
  output logic o_write_busy
);
  localparam int BLK_W = $clog2(NUM_BLOCKS);

  fsp_link_if link ();
  logic [5:0] pins_s;
  wire sck_s = pins_s[5];
  wire cs_n_s = pins_s[4];
  wire si_s = pins_s[3];
  wire wp_n_s = pins_s[2];
  wire ded_n_s = pins_s[1];
  wire hold_n_s = pins_s[0];

  // all pins cross into the clock domain through two flops
  fsp_sync #(.W(6), .RST(PIN_IDLE)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_async({i_sck, i_cs_n, i_si, i_wp_n, i_reset_dedicated_n, i_pause_reset_n}),
    .o_sync(pins_s)
  );

  fsp_serial u_serial (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_sck(sck_s),
    .i_cs_n(cs_n_s),
    .i_si(si_s),
    .link(link.front),
    .o_so(o_so),
    .o_so_oe(o_so_oe)
  );

  // register state
  logic busy_ff, wel_ff, lock_ff, quad_ff, rst_off_ff, ppause_ff, epause_ff;
  logic [3:0] prot_ff, irl_ff;
  fsp_op_e op_kind_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [7:0] opcode_ff, data_ff, tx_ff;
  logic [23:0] addr_ff;
  logic [2:0] nbytes_ff;
  logic seen_ff, tx_en_ff;

  // 64 KB block protection decode
  function automatic logic blk_protected(input logic [3:0] sel, input logic [BLK_W-1:0] blk);
    int s;
    int b;
    logic hit;
    s = int'(sel);
    b = int'(blk);
    hit = 1'b0;
    if (s >= 1 && s <= 5) begin
      hit = b >= NUM_BLOCKS - (1 << (s - 1));
    end else if (s >= 6 && s <= 9) begin
      hit = 1'b1;
    end else if (s >= 10 && s <= 14) begin
      hit = b < (1 << (14 - s));
    end
    return hit;
  endfunction

  // opcode classes
  wire [7:0] op = opcode_ff;
  wire is_prog = (op == OP_PAGE_PROG) | (op == OP_QPROG_A) | (op == OP_QPROG_B);
  wire is_blk_erase = (op == OP_SECT_ERASE_A) | (op == OP_SECT_ERASE_B) |
                      (op == OP_BLK32_ERASE) | (op == OP_BLK64_ERASE);
  wire is_array_erase = (op == OP_ARRAY_ERASE_A) | (op == OP_ARRAY_ERASE_B);
  wire is_misc_nv = (op == OP_RP_NV_WR) | (op == OP_XRP_NV_WR) | (op == OP_ROW_ERASE) |
                    (op == OP_BOOT_WR);
  wire is_read = (op == OP_STAT_RD) | (op == OP_FUNC_RD) | (op == OP_XRP_RD);
  wire is_suspend = op == OP_SUSPEND;
  wire is_resume = op == OP_RESUME;
  wire is_sw_reset = op == OP_SW_RESET;

  // acceptance: a busy device lets only reads, resets and a due suspend through
  wire run_pe = busy_ff & ((op_kind_ff == FSP_OP_PROG) | (op_kind_ff == FSP_OP_ERASE));
  wire busy_pass = is_read | is_sw_reset | (is_suspend & run_pe);
  wire go = link.frame_end & seen_ff & (~busy_ff | busy_pass);

  // guards on write-class commands
  wire has_data = nbytes_ff >= 3'h1;
  wire has_addr = nbytes_ff >= 3'h3;
  wire [BLK_W-1:0] blk = addr_ff[BLK_ADDR_LSB +: BLK_W];
  wire prot_hit = blk_protected(prot_ff, blk);
  wire [1:0] row = addr_ff[ROW_ADDR_LSB +: 2];
  wire hw_locked = lock_ff & ~quad_ff & ~wp_n_s;
  wire no_pause = ~ppause_ff & ~epause_ff;
  // volatile read-register sets are not in any gated class, so they skip the latch
  wire wgo = go & wel_ff;

  wire start_prog = wgo & is_prog & has_addr & ~prot_hit & no_pause;
  wire start_erase = wgo & no_pause &
                     ((is_blk_erase & has_addr & ~prot_hit) |
                      (is_array_erase & (prot_ff == 4'h0)));
  wire do_stat_wr = wgo & (op == OP_STAT_WR) & has_data & ~hw_locked;
  wire do_func_wr = wgo & (op == OP_FUNC_WR) & has_data;
  wire do_row_prog = wgo & (op == OP_ROW_PROG) & has_addr & ~irl_ff[row];
  wire start_reg = do_stat_wr | do_func_wr | do_row_prog | (wgo & is_misc_nv);
  wire do_suspend = go & is_suspend & run_pe;
  wire do_resume = go & is_resume & ~no_pause;
  wire done = busy_ff & (cnt_ff == '0);

  // reset from the selected pin; the shared pin carries data in quad mode
  wire pin_rst = rst_off_ff ? (~quad_ff & ~hold_n_s) : ~ded_n_s;
  wire dev_rst = pin_rst | (go & is_sw_reset);

  // operation length for the command being started
  wire [CNT_W-1:0] start_len = start_prog ? CNT_W'(PROG_LEN - 1) :
                               start_erase ? CNT_W'(ERASE_LEN - 1) : CNT_W'(REG_LEN - 1);

  // frame capture: opcode, then up to four further bytes, the address keeping the last three
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      opcode_ff <= 8'h00;
      addr_ff <= 24'h000000;
      data_ff <= 8'h00;
      nbytes_ff <= 3'h0;
      seen_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (link.frame_end) begin
        seen_ff <= 1'b0;
      end else if (link.byte_stb && link.first_byte) begin
        opcode_ff <= link.rx_byte;
        nbytes_ff <= 3'h0;
        seen_ff <= 1'b1;
      end else if (link.byte_stb && nbytes_ff != 3'h4) begin
        addr_ff <= {addr_ff[15:0], link.rx_byte};
        if (nbytes_ff == 3'h0) begin
          data_ff <= link.rx_byte;
        end
        nbytes_ff <= nbytes_ff + 3'h1;
      end
    end
  end

  // busy flag and operation timer; the timer holds while suspended
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_ff <= 1'b0;
      op_kind_ff <= FSP_OP_IDLE;
      cnt_ff <= '0;
    end else if (i_clk_en) begin
      if (dev_rst) begin
        busy_ff <= 1'b0;
        op_kind_ff <= FSP_OP_IDLE;
      end else if (start_prog | start_erase | start_reg) begin
        busy_ff <= 1'b1;
        cnt_ff <= start_len;
        op_kind_ff <= start_prog ? FSP_OP_PROG : start_erase ? FSP_OP_ERASE : FSP_OP_REG;
      end else if (do_resume) begin
        busy_ff <= 1'b1;
      end else if (done) begin
        busy_ff <= 1'b0;
        op_kind_ff <= FSP_OP_IDLE;
      end else if (do_suspend) begin
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - CNT_W'(1);
      end
    end
  end

  // write latch: enable, disable, cleared by completion; status write leaves it
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wel_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (dev_rst || done) begin
        wel_ff <= 1'b0;
      end else if (go && op == OP_WR_EN) begin
        wel_ff <= 1'b1;
      end else if (go && op == OP_WR_DIS) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // paused flags follow suspend and resume of the interrupted operation
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ppause_ff <= 1'b0;
      epause_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (dev_rst || do_resume) begin
        ppause_ff <= 1'b0;
        epause_ff <= 1'b0;
      end else if (do_suspend) begin
        ppause_ff <= op_kind_ff == FSP_OP_PROG;
        epause_ff <= op_kind_ff == FSP_OP_ERASE;
      end
    end
  end

  // non-volatile status bits: power-on image or status write only
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      lock_ff <= STATUS_RESET[STAT_LOCK];
      quad_ff <= STATUS_RESET[STAT_QUAD];
      prot_ff <= STATUS_RESET[STAT_PROT_LSB +: 4];
    end else if (i_clk_en) begin
      if (i_load_nv) begin
        lock_ff <= i_nv_status[STAT_LOCK];
        quad_ff <= i_nv_status[STAT_QUAD];
        prot_ff <= i_nv_status[STAT_PROT_LSB +: 4];
      end else if (do_stat_wr) begin
        lock_ff <= data_ff[STAT_LOCK];
        quad_ff <= data_ff[STAT_QUAD];
        prot_ff <= data_ff[STAT_PROT_LSB +: 4];
      end
    end
  end

  // one-time bits only gain ones from a function write; bit 1 has no storage
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rst_off_ff <= RST_OFF_DEFAULT;
      irl_ff <= FUNC_RESET[FUNC_IRL_LSB +: 4];
    end else if (i_clk_en) begin
      if (i_load_nv) begin
        rst_off_ff <= i_nv_function[FUNC_RST_OFF];
        irl_ff <= i_nv_function[FUNC_IRL_LSB +: 4];
      end else if (do_func_wr) begin
        rst_off_ff <= rst_off_ff | data_ff[FUNC_RST_OFF];
        irl_ff <= irl_ff | data_ff[FUNC_IRL_LSB +: 4];
      end
    end
  end

  // read words as assembled from the register state
  wire [7:0] stat_word = {lock_ff, quad_ff, prot_ff, wel_ff, busy_ff};
  wire [7:0] func_word = {irl_ff, epause_ff, ppause_ff, 1'b0, rst_off_ff};
  wire [7:0] rd_op = link.first_byte ? link.rx_byte : opcode_ff;
  wire [7:0] rd_word = (rd_op == OP_STAT_RD) ? stat_word :
                       (rd_op == OP_FUNC_RD) ? func_word : 8'h00;
  wire rd_ok = ((rd_op == OP_STAT_RD) | (rd_op == OP_FUNC_RD) | (rd_op == OP_XRP_RD));

  assign link.tx_byte = tx_ff;
  assign link.tx_en = tx_en_ff;

  // reply byte refreshed at every byte boundary so repeated reads track state
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      tx_ff <= 8'h00;
      tx_en_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (link.frame_end) begin
        tx_en_ff <= 1'b0;
      end else if (link.byte_stb) begin
        tx_ff <= rd_word;
        tx_en_ff <= rd_ok;
      end
    end
  end

  // registered copies for the outputs and pin function selects
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_status_word <= STATUS_RESET;
      o_function_word <= FUNC_RESET;
      o_wp_func_en <= 1'b1;
      o_pause_func_en <= 1'b1;
      o_quad_io_en <= 1'b0;
      o_reset_shared_pin <= 1'b0;
      o_write_busy <= 1'b0;
    end else if (i_clk_en) begin
      o_status_word <= stat_word;
      o_function_word <= func_word;
      o_wp_func_en <= ~quad_ff;
      o_pause_func_en <= ~quad_ff;
      o_quad_io_en <= quad_ff;
      o_reset_shared_pin <= rst_off_ff;
      o_write_busy <= busy_ff;
    end
  end
endmodule

// file: core/fsp_pkg.sv
// shared constants and types for the flash status and protection logic
package fsp_pkg;
  // status word bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_PROT_LSB = 2;
  localparam int STAT_QUAD = 6;
  localparam int STAT_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // function word bit positions
  localparam int FUNC_RST_OFF = 0;
  localparam int FUNC_PPAUSE = 2;
  localparam int FUNC_EPAUSE = 3;
  localparam int FUNC_IRL_LSB = 4;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam logic FUNC_RST_OFF_RESET = 1'b0;
  // latch-gated array commands
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG_A = 8'h32;
  localparam logic [7:0] OP_QPROG_B = 8'h38;
  localparam logic [7:0] OP_SECT_ERASE_A = 8'hD7;
  localparam logic [7:0] OP_SECT_ERASE_B = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_ARRAY_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_ARRAY_ERASE_B = 8'h60;
  // latch-gated register and info-row commands
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_FUNC_WR = 8'h42;
  localparam logic [7:0] OP_RP_NV_WR = 8'h65;
  localparam logic [7:0] OP_XRP_NV_WR = 8'h85;
  localparam logic [7:0] OP_ROW_ERASE = 8'h64;
  localparam logic [7:0] OP_ROW_PROG = 8'h62;
  localparam logic [7:0] OP_BOOT_WR = 8'h15;
  // latch, read, suspend and reset commands
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_FUNC_RD = 8'h48;
  localparam logic [7:0] OP_XRP_RD = 8'h81;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_SW_RESET = 8'h99;
  // array geometry: 64 KB protection blocks, info-row select bits
  localparam int PROT_BLOCKS = 32;
  localparam int BLK_ADDR_LSB = 16;
  localparam int ROW_ADDR_LSB = 12;
  // operation durations in clock cycles
  localparam int PROG_CYCLES = 64;
  localparam int ERASE_CYCLES = 256;
  localparam int REG_CYCLES = 32;
  localparam int CNT_W = 16;
  // synchroniser reset image: sck, cs_n, si, wp_n, dedicated reset_n, pause/reset_n
  localparam logic [5:0] PIN_IDLE = 6'h3E;
  typedef enum logic [1:0] {FSP_OP_IDLE, FSP_OP_PROG, FSP_OP_ERASE, FSP_OP_REG} fsp_op_e;
endpackage

// file: core/fsp_link_if.sv
// byte link between the serial front end and the register core
`timescale 1ns/10ps
interface fsp_link_if;
  logic byte_stb;
  logic first_byte;
  logic [7:0] rx_byte;
  logic frame_end;
  logic [7:0] tx_byte;
  logic tx_en;
  modport front (output byte_stb, output first_byte, output rx_byte, output frame_end,
                 input tx_byte, input tx_en);
  modport core (input byte_stb, input first_byte, input rx_byte, input frame_end,
                output tx_byte, output tx_en);
endinterface

// file: core/fsp_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
module fsp_sync import fsp_pkg::*; #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_ff <= RST;
      o_sync <= RST;
    end else if (i_clk_en) begin
      meta_ff <= i_async;
      o_sync <= meta_ff;
    end
  end
endmodule

// file: core/fsp_serial.sv
// serial front end: mode 0 byte receive and transmit on sampled pins
`timescale 1ns/10ps
module fsp_serial import fsp_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  fsp_link_if.front link,
  output logic o_so,
  output logic o_so_oe
);
  logic sck_d_ff, cs_d_ff, first_ff, stb_ff, isfirst_ff, end_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] sh_ff, rx_ff, tx_sh_ff;
  wire sel = ~i_cs_n;
  wire rise = sel & i_sck & ~sck_d_ff;
  wire fall = sel & ~i_sck & sck_d_ff;

  assign link.byte_stb = stb_ff;
  assign link.first_byte = isfirst_ff;
  assign link.rx_byte = rx_ff;
  assign link.frame_end = end_ff;

  // edge history and frame end strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      end_ff <= 1'b0;
    end else if (i_clk_en) begin
      sck_d_ff <= i_sck;
      cs_d_ff <= i_cs_n;
      end_ff <= i_cs_n & ~cs_d_ff;
    end
  end

  // receive: shift on rising sck, strobe every eighth bit
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      bit_cnt_ff <= 3'h0;
      sh_ff <= 8'h00;
      rx_ff <= 8'h00;
      first_ff <= 1'b1;
      stb_ff <= 1'b0;
      isfirst_ff <= 1'b0;
    end else if (i_clk_en) begin
      stb_ff <= rise & (bit_cnt_ff == 3'h7);
      if (!sel) begin
        bit_cnt_ff <= 3'h0;
        first_ff <= 1'b1;
      end else if (rise) begin
        sh_ff <= {sh_ff[6:0], i_si};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (bit_cnt_ff == 3'h7) begin
          rx_ff <= {sh_ff[6:0], i_si};
          isfirst_ff <= first_ff;
          first_ff <= 1'b0;
        end
      end
    end
  end

  // transmit: new byte taken at the first falling edge of each byte slot
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      tx_sh_ff <= 8'h00;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_so_oe <= sel & link.tx_en;
      if (fall && bit_cnt_ff == 3'h0) begin
        o_so <= link.tx_byte[7];
        tx_sh_ff <= {link.tx_byte[6:0], 1'b0};
      end else if (fall) begin
        o_so <= tx_sh_ff[7];
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end
endmodule

// file: verification/fsp_regs_asserts.sv
// concurrent checks on the status and protection register ports
`timescale 1ns/10ps
module fsp_regs_asserts (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic i_load_nv,
  input wire logic [7:0] o_status_word,
  input wire logic [7:0] o_function_word,
  input wire logic o_wp_func_en,
  input wire logic o_quad_io_en,
  input wire logic o_reset_shared_pin,
  input wire logic o_write_busy
);
  // longest busy stretch the bench ever starts, with margin
  localparam int BUSY_MAX = 1000;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  // pin functions and quad data lines are never both selected
  pins_excl_a: assert property (o_wp_func_en == !o_quad_io_en)
    else $error("pin functions disagree with quad enable");
  reserved_zero_a: assert property (o_function_word[1] == 1'b0)
    else $error("reserved function bit reads one");
  // a power-on load may legally lower bits, so it is masked out
  otp_sticky_a: assert property (!$past(i_reset) && !$past(i_load_nv) && !$past(i_load_nv, 2)
    |-> ($past(o_function_word) & ~o_function_word & 8'hF1) == 8'h00)
    else $error("one-time bit returned to zero");
  // eight cycles cover the pin synchroniser before the freeze must hold
  lock_hold_a: assert property ((o_status_word[7] && !o_status_word[6] && !i_wp_n
    && !i_load_nv)[*8] |=> $stable(o_status_word[7:2]))
    else $error("locked status bits changed");
  wel_quiet_a: assert property ((!i_cs_n && !o_status_word[0])[*8]
    |=> $stable(o_status_word[1]))
    else $error("write latch moved inside a frame");
  wel_gate_a: assert property ($rose(o_write_busy) |-> o_status_word[1])
    else $error("operation started without write latch");
  busy_start_a: assert property ($rose(o_write_busy) |-> $past(i_cs_n, 3)
    ##1 o_write_busy[*7])
    else $error("busy rose outside frame end or dropped early");
  busy_end_a: assert property ($rose(o_write_busy) |-> ##[1:BUSY_MAX] !o_write_busy)
    else $error("busy never cleared");
  shared_pin_a: assert property ($rose(o_function_word[0]) |-> ##[0:2] o_reset_shared_pin)
    else $error("reset not moved to shared pin");
  pause_idle_a: assert property ($rose(|o_function_word[3:2]) |-> ##[0:2] !o_write_busy)
    else $error("busy still set while paused");
  cover property ($rose(o_write_busy));
  cover property ($rose(o_function_word[2]));
  cover property ($rose(o_function_word[3]));
  cover property (o_status_word[7] && !i_wp_n);
endmodule
bind fsp_regs fsp_regs_asserts chk (.i_ref_clk, .i_reset, .i_cs_n, .i_wp_n, .i_load_nv,
  .o_status_word, .o_function_word, .o_wp_func_en, .o_quad_io_en, .o_reset_shared_pin,
  .o_write_busy);

// file: verification/fsp_host.sv
// host-side serial controller model driving mode 0 frames
`timescale 1ns/10ps
module fsp_host (
  input wire logic i_ref_clk,
  input wire logic i_so,
  input wire logic i_so_oe,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  // idle: clock parked low, select high
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // n bytes from the top of d; bits after the first byte are read back into rd
  // low phase is five clocks so read data has settled before the rising edge
  task automatic frame(input logic [31:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      o_si <= d[31 - i];
      repeat (5) @(posedge i_ref_clk);
      o_sck <= 1'b1;
      if (i >= 8) rd = {rd[6:0], i_so_oe ? i_so : 1'bx};
      repeat (3) @(posedge i_ref_clk);
      o_sck <= 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    o_si <= ~o_si; // released line shows no stale bit
    repeat (10) @(posedge i_ref_clk);
  endtask
endmodule

// file: verification/test_fsp_regs.sv
// self-checking bench for the flash status and protection registers
`timescale 1ns/10ps
module test_fsp_regs import fsp_pkg::*;;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wp_n = 1'b1;
  logic load_nv = 1'b0;
  logic clk_en = 1'b1;
  logic ded_n = 1'b1;
  logic hold_n = 1'b1;
  logic [7:0] nv_stat = 8'h00;
  logic [7:0] nv_func = 8'h00;
  logic sck, cs_n, si, so, so_oe, wp_en, pause_en, quad_en, rst_sh, busy;
  logic [7:0] stat, func, rd;
  logic [7:0] wr_ops [16] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7,
    8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
  logic [3:0] pcode [4] = '{4'h5, 4'hA, 4'hE, 4'h7};
  logic [4:0] pblk [4] = '{5'h10, 5'h0F, 5'h01, 5'h00};
  logic pok [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int errors = 0;
  int compares = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  // counts lengthened; program and erase outlast several frames, register writes outlast the frame tail so busy can be observed
  fsp_regs #(.PROG_LEN(600), .ERASE_LEN(600), .REG_LEN(40)) DUT (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(clk_en), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_wp_n(wp_n), .i_reset_dedicated_n(ded_n), .i_pause_reset_n(hold_n),
    .i_load_nv(load_nv), .i_nv_status(nv_stat), .i_nv_function(nv_func), .o_so(so),
    .o_so_oe(so_oe), .o_status_word(stat), .o_function_word(func), .o_wp_func_en(wp_en),
    .o_pause_func_en(pause_en), .o_quad_io_en(quad_en), .o_reset_shared_pin(rst_sh),
    .o_write_busy(busy));
  fsp_host host (.i_ref_clk(i_ref_clk), .i_so(so), .i_so_oe(so_oe), .o_sck(sck),
    .o_cs_n(cs_n), .o_si(si));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // frame helpers: opcode alone, opcode with one data byte, opcode with address
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 24'h000000}, 1, rd);
  endtask
  task automatic cmd_d(input logic [7:0] op, input logic [7:0] d);
    host.frame({op, d, 16'h0000}, 2, rd);
  endtask
  task automatic cmd_a(input logic [7:0] op, input logic [23:0] a);
    host.frame({op, a}, 4, rd);
  endtask
  // bounded wait for the running operation to end
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 2000) chk("busy_timeout", 8'h00, 8'h01);
    repeat (4) @(posedge i_ref_clk);
  endtask
  task automatic end_sim();
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_ref_clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    chk("status_rst", 8'h00, stat);
    chk("func_rst", 8'h00, func);
    chk("pins_rst", 8'h06, {5'h0, wp_en, pause_en, quad_en});
    nv_stat <= 8'h3F;
    nv_func <= 8'h0E;
    load_nv <= 1'b1;
    @(posedge i_ref_clk);
    load_nv <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    chk("status_load", 8'h3C, stat);
    chk("func_load", 8'h00, func);
    foreach (wr_ops[k]) begin
      cmd_a(wr_ops[k], 24'h000000);
      chk("no_latch", 8'h3C, stat);
    end
    cmd(OP_WR_EN);
    chk("wel_set", 8'h3E, stat);
    cmd(OP_WR_DIS);
    chk("wel_clr", 8'h3C, stat);
    cmd(OP_WR_EN);
    cmd_d(OP_STAT_WR, 8'h04);
    chk("stat_wr_busy", 8'h07, stat);
    wait_idle();
    chk("stat_wr_done", 8'h04, stat);
    cmd(OP_WR_EN);
    cmd_a(OP_PAGE_PROG, 24'h1F0000);
    chk("prot_top", 8'h06, stat);
    cmd_a(OP_PAGE_PROG, 24'h1E0000);
    chk("prog_busy", 8'h07, stat);
    cmd(OP_WR_DIS);
    cmd_d(OP_STAT_RD, 8'h00);
    chk("rd_busy", 8'h07, rd);
    cmd(OP_SUSPEND);
    chk("susp_stat", 8'h06, stat);
    chk("susp_func", 8'h04, func);
    cmd(OP_RESUME);
    chk("resume_func", 8'h00, func);
    wait_idle();
    chk("prog_done", 8'h04, stat);
    for (int k = 0; k < 4; k++) begin
      cmd(OP_WR_EN);
      cmd_d(OP_STAT_WR, {2'b00, pcode[k], 2'b00});
      wait_idle();
      cmd(OP_WR_EN);
      cmd_a(OP_PAGE_PROG, {3'h0, pblk[k], 16'h0000});
      chk("prot_dec", {2'b00, pcode[k], 1'b1, pok[k]}, stat);
      wait_idle();
    end
    cmd_a(OP_ARRAY_ERASE_A, 24'h000000);
    chk("array_prot", 8'h1E, stat);
    cmd_d(OP_STAT_WR, 8'h00);
    wait_idle();
    cmd(OP_WR_EN);
    cmd(OP_ARRAY_ERASE_B);
    chk("array_run", 8'h03, stat);
    wait_idle();
    cmd(OP_WR_EN);
    cmd_a(OP_BLK64_ERASE, 24'h000000);
    cmd(OP_SUSPEND);
    chk("erase_paused_flag_set", 8'h08, func);
    cmd(OP_RESUME);
    chk("erase_paused_flag_clr", 8'h00, func);
    wait_idle();
    cmd(OP_WR_EN);
    cmd_d(OP_STAT_WR, 8'h80);
    wait_idle();
    wp_n <= 1'b0;
    cmd(OP_WR_EN);
    cmd_d(OP_STAT_WR, 8'h00);
    chk("locked", 8'h82, stat);
    wp_n <= 1'b1;
    cmd_d(OP_STAT_WR, 8'h40);
    wait_idle();
    chk("unlocked", 8'h40, stat);
    chk("quad_pins", 8'h01, {5'h0, wp_en, pause_en, quad_en});
    cmd(OP_WR_EN);
    cmd_d(OP_FUNC_WR, 8'hF3);
    wait_idle();
    chk("func_wr", 8'hF1, func);
    chk("rst_shared", 8'h01, {7'h00, rst_sh});
    cmd(OP_WR_EN);
    cmd_d(OP_FUNC_WR, 8'h00);
    wait_idle();
    chk("otp_keep", 8'hF1, func);
    cmd(OP_WR_EN);
    cmd_a(OP_ROW_PROG, 24'h002000);
    chk("row_locked", 8'h42, stat);
    cmd_d(OP_FUNC_RD, 8'h00);
    chk("func_rd", 8'hF1, rd);
    cmd_d(OP_XRP_RD, 8'h00);
    chk("ext_rd", 8'h00, rd);
    cmd(OP_SW_RESET);
    chk("sw_reset", 8'h40, stat);
    // a frozen block must not see a whole write-enable frame
    clk_en <= 1'b0;
    cmd(OP_WR_EN);
    clk_en <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    chk("clk_en_freeze", 8'h40, stat);
    end_sim();
  end
endmodule
